// ===== include/sdrt_map.vh
`ifndef SDRT_MAP_VH
`define SDRT_MAP_VH
// ----------------------------------------
// fifo geometry
// ----------------------------------------
`define SDRT_FIFO_DEPTH 11'h400
`define SDRT_LVL_W 11
// ----------------------------------------
// raw status bit positions
// ----------------------------------------
`define SDRT_B_RESP_ERR 0
`define SDRT_B_RESP_TMO 1
`define SDRT_B_DATA_CRC 2
`define SDRT_B_DATA_TMO 3
`define SDRT_B_HOST_TMO 4
`define SDRT_B_FIFO_ERR 5
`define SDRT_B_HW_LOCK 6
`define SDRT_B_BIT_ERR 7
`define SDRT_NSTAT 8
// ----------------------------------------
// reset values
// ----------------------------------------
`define SDRT_RST_MASK 8'h00
`define SDRT_RST_INTEN 1'h0
// ----------------------------------------
// timing: response wait in card clock edges
// ----------------------------------------
`define SDRT_RESP_EDGES 8'h40
// host starvation wait, ns, and cycles at 8 ns
`define SDRT_HTO_NS 65536
`define SDRT_CLK_NS 8
`define SDRT_HTO_CYC (`SDRT_HTO_NS / `SDRT_CLK_NS)
`endif

// ===== src/sdrt_core.v
// Overview of operation
// RQ1: software sets threshold to block words
// RQ2: burst field picks 1..256 word transfers
// RQ3: software sets watermark to burst minus one
// RQ4: block size word aligned, under 4096
// RQ5: large block uses full block threshold
// RQ6: reset clears interrupt enable and masks
// RQ7: flag data timeout, expose byte count
// RQ8: response receive error sets response flag
// RQ9: data crc or framing error sets flag
// RQ10: start while buffer busy locks, discards
// RQ11: flag overrun and underrun on fifo
// RQ12: software checks empty/full before access
// RQ13: flag host starvation on slow service
// RQ14: missing ce-ata response is response timeout
// RQ15: negative write crc flags, transfer continues
// RQ16: card sends completion or finishes count
// RQ17: abort read with disable then stop
// RQ18: read issues only with threshold room
// RQ19: threshold only when block fits fifo
// RQ20: own raw bit, masked, globally enabled
`include "sdrt_map.vh"
`default_nettype none
module sdrt_core #(
   parameter HTO_CYCLES = `SDRT_HTO_CYC // starvation limit, shortenable
) (
   input wire core_clk, // controller clock
   input wire rst, // synchronous reset, active high
   input wire ce, // clock enable, freezes all state when low
   input wire card_clk, // card clock pin, sampled
   input wire card_cmd, // card command line pin
   input wire card_dat0, // card data line 0 pin
   input wire start_cmd, // software command start pulse
   input wire cmd_data, // command carries data
   input wire cmd_read, // data direction is card to host
   input wire thr_en, // read threshold enable
   input wire [10:0] thr_words, // read threshold in words
   input wire [2:0] dma_burst_size, // burst code, 1..256 transfers
   input wire [11:0] rx_wmark, // receive watermark
   input wire [11:0] blk_bytes, // block size in bytes
   input wire [15:0] data_tmo, // data start wait, card edges
   input wire card_push, // datapath writes a word into fifo
   input wire card_pop, // datapath takes a word from fifo
   input wire sw_push, // software writes fifo
   input wire sw_pop, // software reads fifo
   input wire data_done, // datapath finished all bytes
   input wire resp_crc_bad, // response crc mismatch
   input wire resp_fmt_bad, // response framing error
   input wire data_crc_bad, // data crc mismatch on a block
   input wire data_sbit_bad, // data start bit not found
   input wire data_ebit_bad, // data end bit not found
   input wire wr_crc_neg, // card returned negative crc status
   input wire abort_req, // request ce-ata read abort
   input wire cfg_wr, // load mask and enable
   input wire [7:0] cfg_mask, // interrupt mask, 1 passes
   input wire cfg_int_en, // global interrupt enable
   input wire [7:0] stat_clr, // write one to clear raw bits
   output reg cmd_issue, // command goes out on the card bus
   output reg completion_signal_disable_send, // completion disable command pulse
   output reg stop_send, // stop transmission pulse
   output wire cmd_busy, // command buffer occupied
   output reg [7:0] raw_stat, // sticky raw status
   output wire intr, // interrupt out
   output reg [10:0] fifo_level, // words in fifo
   output wire fifo_empty, // fifo empty
   output wire fifo_full, // fifo full
   output wire dma_req, // watermark crossed during read
   output wire burst_bad, // burst does not divide block
   output reg [31:0] tcb_count, // bytes moved on the card side of the fifo
   output reg xfer_active // data transfer in progress
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam S_IDLE = 2'h0; // nothing outstanding
   localparam S_WRSP = 2'h1; // waiting for response start
   localparam S_WDAT = 2'h2; // waiting for data start bit
   localparam S_XFER = 2'h3; // data moving
   localparam [10:0] DEPTH = `SDRT_FIFO_DEPTH;
   localparam [31:0] HTO_LIM = HTO_CYCLES;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [2:0] clk_s_q; // card clock, two stages plus history
   reg [1:0] cmd_s_q; // command line stages
   reg [1:0] dat_s_q; // data line stages
   wire clk_rise; // one core cycle per card clock rise
   // stage 0 feeds stage 1 only; edges come from later stages
   always @(posedge core_clk) begin
      if (rst) begin
         clk_s_q <= 3'h0;
         cmd_s_q <= 2'h3;
         dat_s_q <= 2'h3;
      end else if (ce) begin
         clk_s_q <= {clk_s_q[1:0], card_clk};
         cmd_s_q <= {cmd_s_q[0], card_cmd};
         dat_s_q <= {dat_s_q[0], card_dat0};
      end
   end
   assign clk_rise = clk_s_q[1] & ~clk_s_q[2];
   // ----------------------------------------
   // fifo occupancy
   // ----------------------------------------
   wire ovr; // software write into full fifo
   wire unr; // software read from empty fifo
   wire [10:0] free_words; // room left in fifo
   reg [10:0] lvl_d; // next level
   assign fifo_empty = (fifo_level == 11'h000);
   assign fifo_full = (fifo_level == DEPTH);
   assign ovr = sw_push & fifo_full; // [RQ11]
   assign unr = sw_pop & fifo_empty; // [RQ11]
   assign free_words = DEPTH - fifo_level;
   // refused accesses leave the level alone so it never wraps
   always @* begin
      lvl_d = fifo_level;
      if ((card_push | (sw_push & ~ovr)) & ~fifo_full) begin
         lvl_d = lvl_d + 11'h001;
      end
      if ((card_pop | (sw_pop & ~unr)) & ~fifo_empty) begin
         lvl_d = lvl_d - 11'h001;
      end
   end
   always @(posedge core_clk) begin
      if (rst) begin
         fifo_level <= 11'h000;
      end else if (ce) begin
         fifo_level <= lvl_d;
      end
   end
   // ----------------------------------------
   // dma burst and watermark
   // ----------------------------------------
   reg cmd_rd_q; // buffered or running command reads
   reg [8:0] burst_words; // decoded burst length
   // only the eight legal lengths are encodable
   always @* begin
      case (dma_burst_size) // [RQ2]
         3'h0: burst_words = 9'h001;
         3'h1: burst_words = 9'h004;
         3'h2: burst_words = 9'h008;
         3'h3: burst_words = 9'h010;
         3'h4: burst_words = 9'h020;
         3'h5: burst_words = 9'h040;
         3'h6: burst_words = 9'h080;
         default: burst_words = 9'h100;
      endcase
   end
   // lengths are powers of two, so divisibility is a low-bit test
   assign burst_bad = |(blk_bytes[11:2] & {1'b0, burst_words - 9'h001}); // [RQ2]
   assign dma_req = xfer_active & cmd_rd_q & ({1'b0, fifo_level} > rx_wmark);
   // ----------------------------------------
   // command buffer and threshold gate
   // ----------------------------------------
   reg buf_q; // command waiting in buffer
   reg buf_data_q; // buffered command has data
   reg [1:0] st_q; // sequencer state
   wire room_ok; // threshold satisfied
   wire lock_err; // start refused
   wire go; // command leaves the buffer
   assign cmd_busy = buf_q;
   assign lock_err = start_cmd & buf_q; // [RQ10]
   // without the gate a read could stall the card clock mid block
   assign room_ok = ~(thr_en & buf_data_q & cmd_rd_q) | (free_words >= thr_words); // [RQ18]
   assign go = buf_q & room_ok & (st_q == S_IDLE);
   // load, discard on lock, release on issue
   always @(posedge core_clk) begin
      if (rst) begin
         buf_q <= 1'b0;
         buf_data_q <= 1'b0;
         cmd_rd_q <= 1'b0;
         cmd_issue <= 1'b0;
      end else if (ce) begin
         cmd_issue <= go;
         if (go) begin
            buf_q <= 1'b0;
         end else if (start_cmd & ~buf_q) begin
            buf_q <= 1'b1;
            buf_data_q <= cmd_data;
            cmd_rd_q <= cmd_read;
         end
      end
   end
   // ----------------------------------------
   // response and data sequencer
   // ----------------------------------------
   reg [15:0] edge_cnt_q; // card edges spent waiting
   reg rto_p; // response timeout event
   reg dto_p; // data timeout event
   // all waits count card clock rises, so a stopped clock never times out
   always @(posedge core_clk) begin
      if (rst) begin
         st_q <= S_IDLE;
         edge_cnt_q <= 16'h0000;
         xfer_active <= 1'b0;
         rto_p <= 1'b0;
         dto_p <= 1'b0;
      end else if (ce) begin
         rto_p <= 1'b0;
         dto_p <= 1'b0;
         case (st_q)
            S_IDLE: begin
               edge_cnt_q <= 16'h0000;
               if (go) begin
                  st_q <= S_WRSP;
               end
            end
            S_WRSP: begin
               if (~cmd_s_q[1]) begin
                  edge_cnt_q <= 16'h0000;
                  // response start bit seen
                  if (buf_data_q & cmd_rd_q) begin
                     st_q <= S_WDAT;
                  end else if (buf_data_q) begin
                     st_q <= S_XFER;
                     xfer_active <= 1'b1;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end else if (clk_rise) begin
                  if (edge_cnt_q[7:0] == `SDRT_RESP_EDGES) begin
                     // silent ce-ata card after a bad command lands here
                     rto_p <= 1'b1; // [RQ14]
                     st_q <= S_IDLE;
                  end else begin
                     edge_cnt_q <= edge_cnt_q + 16'h0001;
                  end
               end
            end
            S_WDAT: begin
               if (~dat_s_q[1]) begin
                  st_q <= S_XFER;
                  xfer_active <= 1'b1;
               end else if (clk_rise) begin
                  if (edge_cnt_q == data_tmo) begin
                     dto_p <= 1'b1; // [RQ7]
                     st_q <= S_IDLE;
                  end else begin
                     edge_cnt_q <= edge_cnt_q + 16'h0001;
                  end
               end
            end
            S_XFER: begin
               // negative crc status does not stop the write
               if (data_done) begin // [RQ15]
                  st_q <= S_IDLE;
                  xfer_active <= 1'b0;
               end
            end
            default: begin
               st_q <= S_IDLE;
               xfer_active <= 1'b0;
            end
         endcase
      end
   end
   // ----------------------------------------
   // transferred byte count
   // ----------------------------------------
   // cleared at each issue, so it reads how far the last transfer got
   always @(posedge core_clk) begin
      if (rst) begin
         tcb_count <= 32'h00000000;
      end else if (ce) begin
         if (go) begin
            tcb_count <= 32'h00000000;
         end else if (cmd_rd_q ? card_push : card_pop) begin
            tcb_count <= tcb_count + 32'h00000004; // [RQ7]
         end
      end
   end
   // ----------------------------------------
   // host starvation
   // ----------------------------------------
   reg [31:0] hto_cnt_q; // cycles stalled on software
   reg hto_p; // starvation event
   wire starved; // card side blocked by fifo
   assign starved = xfer_active & (cmd_rd_q ? fifo_full : fifo_empty);
   always @(posedge core_clk) begin
      if (rst) begin
         hto_cnt_q <= 32'h00000000;
         hto_p <= 1'b0;
      end else if (ce) begin
         hto_p <= 1'b0;
         if (~starved) begin
            hto_cnt_q <= 32'h00000000;
         end else if (hto_cnt_q == HTO_LIM - 32'h00000001) begin
            hto_p <= 1'b1; // [RQ13]
            hto_cnt_q <= 32'h00000000;
         end else begin
            hto_cnt_q <= hto_cnt_q + 32'h00000001;
         end
      end
   end
   // ----------------------------------------
   // ce-ata abort: disable completion, then stop
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         completion_signal_disable_send <= 1'b0;
         stop_send <= 1'b0;
      end else if (ce) begin
         completion_signal_disable_send <= abort_req & ~completion_signal_disable_send; // [RQ17]
         stop_send <= completion_signal_disable_send; // [RQ17]
      end
   end
   // ----------------------------------------
   // raw status and interrupt gating
   // ----------------------------------------
   reg [7:0] set_v; // events this cycle
   reg [7:0] mask_q; // interrupt mask
   reg int_en_q; // global enable
   always @* begin
      set_v = 8'h00;
      set_v[`SDRT_B_RESP_ERR] = resp_crc_bad | resp_fmt_bad; // [RQ8]
      set_v[`SDRT_B_RESP_TMO] = rto_p; // [RQ14]
      set_v[`SDRT_B_DATA_CRC] = data_crc_bad | wr_crc_neg; // [RQ9] [RQ15]
      set_v[`SDRT_B_DATA_TMO] = dto_p; // [RQ7]
      set_v[`SDRT_B_HOST_TMO] = hto_p; // [RQ13]
      set_v[`SDRT_B_FIFO_ERR] = ovr | unr; // [RQ11]
      set_v[`SDRT_B_HW_LOCK] = lock_err; // [RQ10]
      set_v[`SDRT_B_BIT_ERR] = data_sbit_bad | data_ebit_bad; // [RQ9]
   end
   // a set in the clearing cycle survives
   always @(posedge core_clk) begin
      if (rst) begin
         raw_stat <= 8'h00;
         mask_q <= `SDRT_RST_MASK; // [RQ6]
         int_en_q <= `SDRT_RST_INTEN; // [RQ6]
      end else if (ce) begin
         raw_stat <= (raw_stat & ~stat_clr) | set_v; // [RQ20]
         if (cfg_wr) begin
            mask_q <= cfg_mask;
            int_en_q <= cfg_int_en;
         end
      end
   end
   assign intr = int_en_q & |(raw_stat & mask_q); // [RQ20]
endmodule // sdrt_core
`default_nettype wire

// ===== sim/sdrt_core_assertions.sv
`default_nettype none
module sdrt_core_checker (
   input wire logic core_clk, // clock
   input wire logic rst, // reset
   input wire logic ce, // enable
   input wire logic start_cmd, // load
   input wire logic cmd_busy, // buffer
   input wire logic [7:0] raw_stat, // flags
   input wire logic [7:0] stat_clr, // clear
   input wire logic intr, // irq
   input wire logic resp_crc_bad, // event
   input wire logic resp_fmt_bad, // event
   input wire logic data_crc_bad, // event
   input wire logic wr_crc_neg, // event
   input wire logic data_sbit_bad, // event
   input wire logic sw_push, // fifo in
   input wire logic sw_pop, // fifo out
   input wire logic card_push, // card in
   input wire logic fifo_full, // full
   input wire logic fifo_empty, // empty
   input wire logic [10:0] fifo_level, // level
   input wire logic cmd_issue, // issue
   input wire logic thr_en, // gate on
   input wire logic cmd_read, // read
   input wire logic cmd_data, // data
   input wire logic [10:0] thr_words, // gate
   input wire logic abort_req, // abort
   input wire logic completion_signal_disable_send, // disable
   input wire logic stop_send, // stop
   input wire logic xfer_active // busy
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // one clock domain, reset kills attempts
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   reset_clear_a: assert property ($fell(rst) |-> raw_stat == 8'h00 && !intr && !cmd_busy)
      else $error("state not clear after reset");
   lock_flag_a: assert property (ce && start_cmd && cmd_busy |=> raw_stat[6])
      else $error("start into busy buffer not flagged");
   resp_err_a: assert property (ce && (resp_crc_bad || resp_fmt_bad) |=> raw_stat[0])
      else $error("response error not flagged");
   data_err_a: assert property (ce && (data_crc_bad || wr_crc_neg) |=> raw_stat[2])
      else $error("data crc not flagged");
   start_bit_a: assert property (ce && data_sbit_bad |=> raw_stat[7])
      else $error("start bit error not flagged");
   fifo_err_a: assert property (ce && !card_push && ((sw_push && fifo_full)
      || (sw_pop && fifo_empty)) |=> raw_stat[5] && $stable(fifo_level))
      else $error("fifo misuse not flagged");
   thr_room_a: assert property (cmd_issue && thr_en && cmd_read && cmd_data
      |-> 11'h400 - $past(fifo_level) >= thr_words)
      else $error("read issued without room");
   issue_pulse_a: assert property (cmd_issue |=> !cmd_issue)
      else $error("issue longer than one cycle");
   abort_seq_a: assert property (ce && abort_req |=> completion_signal_disable_send ##1 stop_send)
      else $error("abort sequence wrong");
   intr_gate_a: assert property (raw_stat == 8'h00 |-> !intr)
      else $error("interrupt without cause");
   flag_hold_a: assert property (raw_stat[5] && !stat_clr[5] |=> raw_stat[5])
      else $error("flag lost without clear");
   cover property (cmd_issue && cmd_read);
   cover property ($rose(xfer_active));
   cover property (raw_stat[4]);
   cover property (intr);
endmodule // sdrt_core_checker
bind sdrt_core sdrt_core_checker u_chk (.*);
`default_nettype wire

// ===== sim/sdrt_card_model.sv
`default_nettype none
module sdrt_card_model (
   input wire logic cmd_issue, // command leaves controller
   input wire logic resp_en, // card answers
   input wire logic data_en, // card sends data
   output logic card_clk, // still between frames
   output logic card_cmd, // pulled up when released
   output logic card_dat0, // pulled up when released
   output logic frm // frame running
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // one frame of 80 card clock rises per command
   // ----------------------------------------
   initial begin
      card_clk = 1'b0;
      card_cmd = 1'b1;
      card_dat0 = 1'b1;
      frm = 1'b0;
   end
   always @(posedge cmd_issue) begin
      // start off the core clock edge so pin changes never race the sampler
      #2;
      frm = 1'b1;
      for (int n = 0; n < 80; n++) begin
         #32 card_clk = 1'b1;
         #32 card_clk = 1'b0;
         card_cmd = !(resp_en && n == 4); // silent on a bad command
         card_dat0 = !(data_en && n == 8); // block start, count run out
      end
      frm = 1'b0;
   end
endmodule // sdrt_card_model
`default_nettype wire

// ===== sim/sd_card_read_threshold_and_errors_tb.sv
`default_nettype none
module sd_card_read_threshold_and_errors_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // stimulus, pulses packed in one vector
   // ----------------------------------------
   logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, card_pop = 1'b0;
   logic cmd_data = 1'b0, cmd_read = 1'b0, thr_en = 1'b0, cfg_int_en = 1'b0;
   logic resp_en = 1'b1, data_en = 1'b1; // card behaviour
   logic [12:0] pl = 13'h0000; // single cycle inputs
   logic [10:0] thr_words = 11'h000;
   logic [2:0] dma_burst_size = 3'h0;
   logic [11:0] rx_wmark = 12'h07F, blk_bytes = 12'h200;
   logic [15:0] data_tmo = 16'h0010;
   logic [7:0] cfg_mask = 8'h01, stat_clr = 8'h00;
   logic card_clk, card_cmd, card_dat0, frm, cmd_issue, completion_signal_disable_send, stop_send, cmd_busy, intr;
   logic fifo_empty, fifo_full, dma_req, burst_bad, xfer_active;
   logic [7:0] raw_stat;
   logic [10:0] fifo_level;
   logic [31:0] tcb_count;
   int failures = 0, n_checks = 0, n_issue = 0;
   localparam int ST = 0, CP = 1, SP = 2, SO = 3, DD = 4, AB = 5, CW = 6;
   always #4 core_clk = !core_clk;
   // issue pulses counted at the edge, where they are stable
   always @(posedge core_clk) if (cmd_issue === 1'b1) n_issue++;
   sdrt_core #(.HTO_CYCLES(16)) DUT (.*, .start_cmd(pl[0]), .card_push(pl[1]), .sw_push(pl[2]),
      .sw_pop(pl[3]), .data_done(pl[4]), .abort_req(pl[5]), .cfg_wr(pl[6]),
      .resp_crc_bad(pl[7]), .resp_fmt_bad(pl[8]), .data_crc_bad(pl[9]),
      .data_sbit_bad(pl[10]), .data_ebit_bad(pl[11]), .wr_crc_neg(pl[12]));
   sdrt_card_model card (.*);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // hold one pulse input for n edges, then settle
   task automatic go(input int b, input int n);
      @(posedge core_clk) pl <= 13'h0001 << b;
      repeat (n) @(posedge core_clk);
      pl <= 13'h0000;
      #1;
   endtask
   task automatic clr();
      @(posedge core_clk) stat_clr <= 8'hFF;
      @(posedge core_clk) stat_clr <= 8'h00;
   endtask
   task automatic wait_frame();
      for (int i = 0; i < 2000 && frm !== 1'b1; i++) @(posedge core_clk);
      for (int i = 0; i < 2000 && frm !== 1'b0; i++) @(posedge core_clk);
      #1;
   endtask
   task automatic t_events();
      static int pos[6] = '{0, 0, 2, 7, 7, 2};
      cfg_int_en <= 1'b1;
      go(CW, 1);
      for (int i = 0; i < 6; i++) begin
         go(7 + i, 1);
         chk("raw_stat", 8'h01 << pos[i], raw_stat);
         chk("intr", i < 2, intr);
         clr();
      end
      // event and clear in one cycle: the event must survive
      @(posedge core_clk) stat_clr <= 8'hFF;
      pl <= 13'h0080;
      @(posedge core_clk) stat_clr <= 8'h00;
      pl <= 13'h0000;
      #1;
      chk("set wins", 8'h01, raw_stat);
      cfg_int_en <= 1'b0;
      go(CW, 1);
      go(7, 1);
      chk("intr off", 0, intr);
      clr();
   endtask
   task automatic t_lock();
      int i0 = n_issue;
      go(ST, 2); // second start meets a full buffer
      chk("lock", 8'h40, raw_stat);
      wait_frame();
      chk("issues", i0 + 1, n_issue);
      clr();
   endtask
   task automatic t_tmo();
      resp_en <= 1'b0;
      go(ST, 1);
      wait_frame();
      chk("resp tmo", 8'h02, raw_stat);
      clr();
      resp_en <= 1'b1;
      data_en <= 1'b0;
      cmd_data <= 1'b1;
      cmd_read <= 1'b1;
      go(ST, 1);
      wait_frame();
      chk("data tmo", 8'h08, raw_stat);
      clr();
      data_en <= 1'b1;
   endtask
   task automatic t_read();
      int i0;
      thr_en <= 1'b1;
      thr_words <= 11'h300; // full block, over half the fifo
      blk_bytes <= 12'hC00; // 768 words, fits the fifo
      dma_burst_size <= 3'h6; // 128 word bursts
      rx_wmark <= 12'h07F; // burst minus one
      go(CP, 257);
      chk("burst ok", 0, burst_bad);
      i0 = n_issue;
      go(ST, 1);
      repeat (20) @(posedge core_clk);
      chk("held", i0, n_issue);
      chk("busy", 1, cmd_busy);
      go(SO, 1); // free space now equals the threshold
      for (int i = 0; i < 1500 && xfer_active !== 1'b1; i++) @(posedge core_clk);
      chk("issued", i0 + 1, n_issue);
      #1;
      chk("dma_req", 1, dma_req);
      go(CP, 768);
      repeat (20) @(posedge core_clk);
      #1;
      chk("starve", 8'h10, raw_stat);
      chk("bytes", 32'h00000C00, tcb_count);
      chk("full", 1, fifo_full);
      go(SP, 1);
      chk("overrun", {8'h30, 11'h400}, {raw_stat, fifo_level});
      go(DD, 1);
      chk("active", 0, xfer_active);
      clr();
      go(SO, 1025);
      chk("underrun", {8'h20, 11'h000}, {raw_stat, fifo_level});
      clr();
   endtask
   // write transfer: starvation on empty, negative crc keeps it running
   task automatic t_write();
      cmd_read <= 1'b0;
      go(ST, 1);
      for (int i = 0; i < 1500 && xfer_active !== 1'b1; i++) @(posedge core_clk);
      repeat (20) @(posedge core_clk);
      #1;
      chk("wr starve", 8'h10, raw_stat);
      chk("empty", 1, fifo_empty);
      go(SP, 2);
      @(posedge core_clk) card_pop <= 1'b1;
      @(posedge core_clk) card_pop <= 1'b0;
      go(12, 1);
      chk("wr crc", 8'h14, raw_stat);
      chk("wr going", 1, xfer_active);
      chk("wr bytes", 4, tcb_count);
      go(DD, 1);
      go(SO, 1);
      chk("wr done", {1'b0, 11'h000}, {xfer_active, fifo_level});
      clr();
   endtask
   task automatic t_burst();
      static logic [11:0] bb[2] = '{12'h200, 12'h00C};
      for (int j = 0; j < 2; j++) begin
         for (int c = 0; c < 8; c++) begin
            @(posedge core_clk);
            blk_bytes <= bb[j];
            dma_burst_size <= 3'(c);
            #1;
            chk("burst", c == 7 || (j == 1 && c != 0), burst_bad);
         end
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk("reset", 0, {raw_stat, intr, cmd_busy, cmd_issue, fifo_level});
      t_events();
      t_lock();
      t_tmo();
      t_read();
      go(AB, 1);
      chk("completion_signal_disable", 1, completion_signal_disable_send);
      @(posedge core_clk) #1;
      chk("stop", 2'b01, {completion_signal_disable_send, stop_send});
      t_write();
      // enable low: pushes must not move the level
      ce <= 1'b0;
      go(CP, 4);
      chk("freeze", {1'b0, 11'h000}, {cmd_busy, fifo_level});
      ce <= 1'b1;
      t_burst();
      end_sim();
   end
   // watchdog, about nine times the expected run
   initial begin
      #300us;
      failures++;
      end_sim();
   end
endmodule // sd_card_read_threshold_and_errors_tb
`default_nettype wire
